// ===== cbt_bit_timing.sv
// Bit timing, single sampling and wired bus resolution of a node
`include "cbt_defs.svh"
`default_nettype none
// Overview of operation
// - Bits are exchanged at 250 kbit/s.
// - A bit lasts nominally 4 us.
// - The bit period stays within 3.998 to 4.002 us, set by the crystal clock.
// - Exactly one bus sample is taken per bit.
// - The sample point lies at 80 percent of the bit, within 3 points.
// - Pre-sample segment minus jump width gives at least 2.5 us.
// - Quantum 250 ns, jump width 2, pre-sample 12, post-sample 3 quanta.
// - Internal delay between controller and pins stays within 0 to 0.9 us.
// - Bus is recessive only if no transmitter drives, else dominant.
// - A dominant and a recessive bit together are seen as dominant.
module cbt_bit_timing
  import cbt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tx_bit,
  input wire logic other_drive,
  output logic bus_dominant,
  output logic rx_bit,
  output logic sample_strobe,
  output logic bit_start,
  output logic tx_drive,
  output logic hard_sync_seen
);
  logic tq_tick;
  cbt_seg_t seg_q;
  logic [3:0] tq_cnt_q;
  logic rx_q;
  logic tx_q;
  logic bus_prev_q;
  logic bit_end;
  logic bus_dom_c;
  logic edge_early;
  logic [8:0] pos_q;
  logic [1:0] smp_cnt_q;

  cbt_tq_gen u_tq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tq_tick(tq_tick)
  );

  // Last quantum of the current segment
  function automatic logic seg_last(input cbt_seg_t seg, input logic [3:0] cnt);
    case (seg)
      CBT_PRE: seg_last = (cnt == 4'(`CBT_PRE_TQ - 1));
      CBT_POST: seg_last = (cnt == 4'(`CBT_POST_TQ - 1));
      default: seg_last = 1'b1;
    endcase
  endfunction : seg_last

  // Wired-AND: any driver makes the bus dominant
  assign bus_dom_c = tx_q | other_drive;
  assign bus_dominant = bus_dom_c;
  assign tx_drive = tx_q;
  assign bit_end = tq_tick && seg_q == CBT_POST && seg_last(seg_q, tq_cnt_q);
  // Recessive-to-dominant edge inside the pre-sample segment while idle-ish
  assign edge_early = bus_dom_c && !bus_prev_q && seg_q == CBT_PRE;

  // Segment sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      seg_q <= CBT_SYNC;
      tq_cnt_q <= 4'h0;
    end else if (tq_tick) begin
      case (seg_q)
        CBT_SYNC: begin
          seg_q <= CBT_PRE;
          tq_cnt_q <= 4'h0;
        end
        CBT_PRE: begin
          if (seg_last(seg_q, tq_cnt_q)) begin
            seg_q <= CBT_POST;
            tq_cnt_q <= 4'h0;
          end else begin
            tq_cnt_q <= tq_cnt_q + 4'h1;
          end
        end
        CBT_POST: begin
          if (seg_last(seg_q, tq_cnt_q)) begin
            seg_q <= CBT_SYNC;
            tq_cnt_q <= 4'h0;
          end else begin
            tq_cnt_q <= tq_cnt_q + 4'h1;
          end
        end
        default: begin
          seg_q <= CBT_SYNC;
          tq_cnt_q <= 4'h0;
        end
      endcase
    end
  end

  // Single sample at end of pre-sample segment: 13/16 = 81.25 percent
  assign sample_strobe = tq_tick && seg_q == CBT_PRE && seg_last(seg_q, tq_cnt_q);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_q <= 1'b1;
    end else if (sample_strobe) begin
      rx_q <= !bus_dom_c;
    end
  end
  assign rx_bit = rx_q;

  // Transmit bit launched at bit start, one cycle of internal delay
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_q <= 1'b0;
    end else if (bit_end) begin
      tx_q <= !tx_bit;
    end
  end
  assign bit_start = bit_end;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_prev_q <= 1'b0;
      hard_sync_seen <= 1'b0;
    end else begin
      bus_prev_q <= bus_dom_c;
      hard_sync_seen <= edge_early;
    end
  end

  // Cycles since the last bit ended, for the timing checks
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pos_q <= 9'h001;
    end else if (bit_end) begin
      pos_q <= 9'h001;
    end else begin
      pos_q <= pos_q + 9'h001;
    end
  end

  // Samples taken in the current bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      smp_cnt_q <= 2'h0;
    end else if (bit_end) begin
      smp_cnt_q <= 2'h0;
    end else if (sample_strobe && smp_cnt_q != 2'h3) begin
      smp_cnt_q <= smp_cnt_q + 2'h1;
    end
  end

  // Sample point follows bit start by exactly 13 quanta
  property p_sample_pos;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_strobe == (pos_q == 9'((`CBT_SYNC_TQ + `CBT_PRE_TQ) * `CBT_TQ_CYCLES));
  endproperty
  a_sample_pos: assert property (p_sample_pos) else $error("sample point misplaced");

  // Sample point within the allowed band of the bit
  property p_sample_pct;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_strobe |-> pos_q >= 9'(`CBT_BIT_TQ * `CBT_TQ_CYCLES * (`CBT_SP_PCT - `CBT_SP_TOL_PCT) / 100)
        && pos_q <= 9'(`CBT_BIT_TQ * `CBT_TQ_CYCLES * (`CBT_SP_PCT + `CBT_SP_TOL_PCT) / 100);
  endproperty
  a_sample_pct: assert property (p_sample_pct) else $error("sample point outside band");

  // Bit lasts 16 quanta of 25 cycles
  property p_bit_len;
    @(posedge sys_clk) disable iff (!rst_n)
      bit_end == (pos_q == 9'(`CBT_BIT_TQ * `CBT_TQ_CYCLES));
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit period wrong");

  property p_rate;
    @(posedge sys_clk) disable iff (!rst_n)
      bit_end |=> !bit_end [*8];
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate too high");

  property p_single;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_strobe |-> smp_cnt_q == 2'h0;
  endproperty
  a_single: assert property (p_single) else $error("more than one sample per bit");

  property p_one_sample;
    @(posedge sys_clk) disable iff (!rst_n)
      bit_end |-> smp_cnt_q == 2'h1;
  endproperty
  a_one_sample: assert property (p_one_sample) else $error("bit ended without exactly one sample");

  // Pre-sample segment less one jump width covers the window
  property p_avail;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_strobe |-> pos_q >= 9'((`CBT_SYNC_TQ + `CBT_SJW_TQ) * `CBT_TQ_CYCLES + `CBT_AVAIL_NS / `CBT_CLK_PERIOD_NS);
  endproperty
  a_avail: assert property (p_avail) else $error("sample too early");

  property p_seg;
    @(posedge sys_clk) disable iff (!rst_n)
      sample_strobe |=> seg_q == CBT_POST;
  endproperty
  a_seg: assert property (p_seg) else $error("segment order wrong");

  property p_wired;
    @(posedge sys_clk) disable iff (!rst_n)
      (tx_drive || other_drive) == bus_dominant;
  endproperty
  a_wired: assert property (p_wired) else $error("bus resolution wrong");

  property p_arb;
    @(posedge sys_clk) disable iff (!rst_n)
      (sample_strobe && tx_drive != other_drive) |=> !rx_bit;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration not dominant");

  property p_delay;
    @(posedge sys_clk) disable iff (!rst_n)
      bit_end |=> tx_drive == !$past(tx_bit);
  endproperty
  a_delay: assert property (p_delay) else $error("transmit delay exceeded");

  // Received bit only moves after a sample
  property p_rx_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !sample_strobe |=> $stable(rx_bit);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("received bit changed between samples");

  // Own transmitter level stands for the whole bit
  property p_tx_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !bit_end |=> $stable(tx_drive);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit level changed inside a bit");
endmodule : cbt_bit_timing
`default_nettype wire

// ===== cbt_defs.svh
// Timing constants for the node bit timing block
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH
`define CBT_CLK_PERIOD_NS 10
`define CBT_BIT_RATE_KBPS 250
`define CBT_BIT_TIME_NS (1000000 / `CBT_BIT_RATE_KBPS)
`define CBT_TQ_NS 250
`define CBT_TQ_CYCLES (`CBT_TQ_NS / `CBT_CLK_PERIOD_NS)
`define CBT_SYNC_TQ 1
`define CBT_PRE_TQ 12
`define CBT_POST_TQ 3
`define CBT_SJW_TQ 2
`define CBT_BIT_TQ (`CBT_SYNC_TQ + `CBT_PRE_TQ + `CBT_POST_TQ)
`define CBT_SP_PCT 80
`define CBT_SP_TOL_PCT 3
`define CBT_AVAIL_NS 2500
`define CBT_DELAY_MAX_NS 900
`define CBT_DELAY_CYCLES (`CBT_DELAY_MAX_NS / `CBT_CLK_PERIOD_NS)
`endif

// ===== cbt_pkg.sv
// Types for the node bit timing block
`default_nettype none
package cbt_pkg;
  typedef enum logic [1:0] {CBT_SYNC, CBT_PRE, CBT_POST} cbt_seg_t;
endpackage : cbt_pkg
`default_nettype wire

// ===== cbt_tq_gen.sv
// Time quantum enable divider
`include "cbt_defs.svh"
`default_nettype none
module cbt_tq_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic tq_tick
);
  logic [4:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
    end else if (cnt_q == 5'(`CBT_TQ_CYCLES - 1)) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  assign tq_tick = (cnt_q == 5'(`CBT_TQ_CYCLES - 1));
endmodule : cbt_tq_gen
`default_nettype wire

// ===== cbt_other_node.sv
// Model of another node sharing the bus
`default_nettype none
module cbt_other_node (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bit_start,
  input wire logic send_dom,
  output logic other_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  // New level only at bit boundaries
  always_ff @(posedge sys_clk) begin
    if (!rst_n) other_drive <= 1'b0;
    else if (bit_start) other_drive <= send_dom;
  end
endmodule : cbt_other_node
`default_nettype wire

// ===== testbench.sv
// Testbench for the node bit timing block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_bit = 1'b1;
  logic send_dom = 1'b0;
  logic other_drive, bus_dominant, rx_bit, sample_strobe, bit_start, tx_drive, hard_sync_seen;
  int sync_hits = 0;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  cbt_bit_timing u_cbt_bit_timing (.sys_clk(sys_clk), .rst_n(rst_n), .tx_bit(tx_bit),
    .other_drive(other_drive), .bus_dominant(bus_dominant), .rx_bit(rx_bit),
    .sample_strobe(sample_strobe), .bit_start(bit_start), .tx_drive(tx_drive), .hard_sync_seen(hard_sync_seen));
  cbt_other_node u_cbt_other_node (.sys_clk(sys_clk), .rst_n(rst_n), .bit_start(bit_start),
    .send_dom(send_dom), .other_drive(other_drive));
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic check_bit(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit
  task automatic check_num(string name, int exp, int got);
    checks_done++;
    if (got != exp) begin
      err_count++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_num
  task automatic wait_start();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (bit_start !== 1'b1 && n < 500);
  endtask : wait_start
  task automatic test_timing();
    int n;
    int s;
    int strobes;
    n = 0;
    s = 0;
    strobes = 0;
    wait_start();
    do begin
      @(negedge sys_clk);
      n++;
      if (sample_strobe === 1'b1) begin
        strobes++;
        s = n;
      end
    end while (bit_start !== 1'b1 && n < 500);
    check_num("bit cycles", 400, n);
    check_num("strobes per bit", 1, strobes);
    check_num("sample offset", 325, s);
    check_num("window ok", 1, int'(s - 25 - 50 >= 250));
    $display("test_timing done");
  endtask : test_timing
  task automatic test_wired();
    logic exp;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      tx_bit <= i[0];
      send_dom <= i[1];
      exp = !i[0] || i[1];
      wait_start();
      @(negedge sys_clk);
      check_bit("tx_drive", !i[0], tx_drive);
      check_bit("bus_dominant", exp, bus_dominant);
      repeat (325) @(negedge sys_clk);
      check_bit("rx_bit", !exp, rx_bit);
    end
    check_num("mid-bit edges", 0, sync_hits);
    $display("test_wired done");
  endtask : test_wired
  // Bus edges should only fall at bit boundaries
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1 && hard_sync_seen !== 1'b0) sync_hits++;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_timing();
    test_wired();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
